// ---- common/lscs_pkg.sv ----
// constants shared by the low-speed clock select block and its helpers
// assumes a single 100 MHz register clock and an apb master on the same clock
//
// Behaviour
// - a 32.768kHz slow crystal is a selectable low-frequency source, enabled by config
// - crystal pins serve the oscillator only when it feeds a clock, else released
// - one bit in time base control picks crystal mode: 0 quick start, 1 low power
// - after reset the low power select bit is zero, crystal starts quick
// - the crystal stays enabled in either mode; mode only changes current
// - an internal 32kHz rc oscillator is the alternative slow source, by config
// - slow clocks also feed watchdog, time base and timer modules
// - system clock comes from fast or substitute clock by high/low and divider bits
// - fast clock comes from fast crystal or fast rc, fixed by config
// - divided fast clocks from /2 to /64 are system clock choices
// - substitute and time base clocks come from slow crystal or slow rc by config
// - substitute clock may serve as temporary system clock right after wake-up
// - moving to substitute clock stops the fast oscillator
// - sleep or idle gates the cpu clock off while slow clocks run on
// - divider field: 000/001 substitute, 010 /64 up to 111 /2
// - high/low bit 1 routes undivided fast clock, 0 the divider choice
package lscs_pkg;

  // apb byte offsets
  localparam logic [7:0] LSCS_SYSTEM_MODE_REG_OFS = 8'h00;
  localparam logic [7:0] LSCS_TBC_OFS = 8'h04;
  localparam logic [7:0] LSCS_CFG_OFS = 8'h08;

  // system mode register fields
  localparam int LSCS_HL_BIT = 0;
  localparam int LSCS_IDLE_BIT = 1;
  localparam int LSCS_FRDY_BIT = 2;
  localparam int LSCS_SRDY_BIT = 3;
  localparam int LSCS_FWAKE_BIT = 4;
  localparam int LSCS_DIV_LSB = 5;
  localparam logic [7:0] LSCS_SYSTEM_MODE_REG_RST = 8'h03;

  // time base control register fields
  localparam int LSCS_LP_BIT = 0;
  localparam logic [7:0] LSCS_TBC_RST = 8'h00;

  // configuration register fields
  localparam int LSCS_CFG_FAST_RC_BIT = 0;
  localparam int LSCS_CFG_SUB_RC_BIT = 1;
  localparam int LSCS_CFG_TB_RC_BIT = 2;
  localparam logic [7:0] LSCS_CFG_RST = 8'h00;

  // clock mux source indices
  localparam int LSCS_NSRC = 8;
  localparam logic [2:0] LSCS_SRC_SUB = 3'h0;
  localparam logic [2:0] LSCS_SRC_FAST = 3'h1;
  localparam logic [2:0] LSCS_SRC_DIV_BASE = 3'h2;
  localparam int LSCS_DIV_W = 6;

  // nominal oscillator rates, informative only
  localparam int LSCS_SLOW_XTAL_HZ_X1000 = 32768000;
  localparam int LSCS_SLOW_RC_HZ = 32000;

  typedef enum logic [1:0] {
    LSCS_MUX_RUN = 2'b00,
    LSCS_MUX_PARK = 2'b01
  } lscs_mux_state_type;

endpackage : lscs_pkg

// ---- core/lscs_clk_mux.sv ----
// glitch-free clock selector with a stop input
// assumes every source is a registered level in the clk_i domain
`timescale 1ns/1ns
`default_nettype none
module lscs_clk_mux #(
  parameter int NSRC = lscs_pkg::LSCS_NSRC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [NSRC-1:0] src_i,
  input wire logic [2:0] req_i,
  input wire logic run_i,
  output logic [2:0] cur_o,
  output logic out_o
);
  import lscs_pkg::*;

  lscs_mux_state_type state_r;
  lscs_mux_state_type state_nxt;
  logic [2:0] cur_r;
  logic [2:0] cur_nxt;
  logic out_r;
  logic out_nxt;

  // leave a source only while it is low, and join the new one only while
  // it is low too: the first high level seen is always a whole pulse
  always_comb begin
    state_nxt = state_r;
    cur_nxt = cur_r;
    case (state_r)
      LSCS_MUX_RUN: begin
        if (((req_i != cur_r) || !run_i) && !src_i[cur_r]) begin
          state_nxt = LSCS_MUX_PARK;
        end
      end
      LSCS_MUX_PARK: begin
        if (run_i && !src_i[req_i]) begin
          cur_nxt = req_i;
          state_nxt = LSCS_MUX_RUN;
        end
      end
      default: begin
        state_nxt = LSCS_MUX_PARK;
      end
    endcase
    out_nxt = (state_nxt == LSCS_MUX_RUN) ? src_i[cur_nxt] : 1'b0;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= LSCS_MUX_PARK;
      cur_r <= LSCS_SRC_SUB;
      out_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cur_r <= cur_nxt;
      out_r <= out_nxt;
    end
  end

  assign cur_o = cur_r;
  assign out_o = out_r;

endmodule : lscs_clk_mux
`default_nettype wire

// ---- core/lscs_fast_div.sv ----
// ripple-free divider of the fast clock, sampled into the register clock
// assumes fast_tick_i is a one-cycle pulse per rising edge of the fast clock
`timescale 1ns/1ns
`default_nettype none
module lscs_fast_div #(
  parameter int DIV_W = lscs_pkg::LSCS_DIV_W
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic fast_tick_i,
  output logic [DIV_W-1:0] div_clk_o
);
  import lscs_pkg::*;

  logic [DIV_W-1:0] cnt_r;
  logic [DIV_W-1:0] cnt_nxt;

  // bit k toggles every 2^k fast edges, so it is fast/2^(k+1)
  always_comb begin
    cnt_nxt = cnt_r;
    if (fast_tick_i) begin
      cnt_nxt = cnt_r + {{(DIV_W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign div_clk_o = cnt_r;

endmodule : lscs_fast_div
`default_nettype wire

// ---- core/lscs_top.sv ----
// low-speed clock select: source routing, system clock mux, apb registers
// assumes oscillator levels and ready flags arrive asynchronously on pins,
// and that clk_i is fast enough to sample the fastest oscillator
`timescale 1ns/1ns
`default_nettype none
module lscs_top (
  input wire logic clk_i,
  input wire logic rst_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // oscillator pins
  input wire logic ext_fast_crystal_osc_i,
  input wire logic int_fast_rc_osc_i,
  input wire logic ext_slow_crystal_osc_i,
  input wire logic int_slow_rc_osc_i,
  input wire logic fast_osc_stable_i,
  input wire logic slow_osc_stable_i,
  // cpu side
  input wire logic halt_i,
  // oscillator controls
  output logic fast_osc_en_o,
  output logic slow_crystal_en_o,
  output logic slow_crystal_pins_osc_o,
  output logic slow_crystal_low_power_select_o,
  // clocks as registered levels
  output logic cpu_system_clock_o,
  output logic high_speed_clock_o,
  output logic substitute_clock_o,
  output logic time_base_clock_o,
  output logic watchdog_clock_o,
  output logic timer_slow_clock_o
);
  import lscs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: three stages, accept when stages two and three agree

  localparam int NPIN = 6;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_s1_r;
  logic [NPIN-1:0] pin_s2_r;
  logic [NPIN-1:0] pin_s3_r;
  logic [NPIN-1:0] pin_f_r;
  logic [NPIN-1:0] pin_f_nxt;

  assign pin_raw = {slow_osc_stable_i, fast_osc_stable_i, int_slow_rc_osc_i,
                    ext_slow_crystal_osc_i, int_fast_rc_osc_i, ext_fast_crystal_osc_i};

  always_comb begin
    pin_f_nxt = pin_f_r;
    for (int i = 0; i < NPIN; i++) begin
      if (pin_s2_r[i] == pin_s3_r[i]) begin
        pin_f_nxt[i] = pin_s2_r[i];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      pin_s3_r <= '0;
      pin_f_r <= '0;
    end else begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      pin_f_r <= pin_f_nxt;
    end
  end

  logic fast_xtal_f;
  logic fast_rc_f;
  logic slow_xtal_f;
  logic slow_rc_f;
  logic fast_stable_f;
  logic slow_stable_f;
  assign fast_xtal_f = pin_f_r[0];
  assign fast_rc_f = pin_f_r[1];
  assign slow_xtal_f = pin_f_r[2];
  assign slow_rc_f = pin_f_r[3];
  assign fast_stable_f = pin_f_r[4];
  assign slow_stable_f = pin_f_r[5];

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [7:0] system_mode_reg_r;
  logic [7:0] system_mode_reg_nxt;
  logic [7:0] tbc_r;
  logic [7:0] tbc_nxt;
  logic [7:0] cfg_r;
  logic [7:0] cfg_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic pready_r;
  logic pready_nxt;
  logic pslverr_r;
  logic pslverr_nxt;
  logic fast_ready;

  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == LSCS_SYSTEM_MODE_REG_OFS) || (a == LSCS_TBC_OFS) || (a == LSCS_CFG_OFS);
  endfunction : addr_hit

  logic setup_ph;
  logic access_wr;
  assign setup_ph = psel_i && !penable_i;
  assign access_wr = psel_i && penable_i && pready_r && pwrite_i && !pslverr_r;

  // ready flags are read-only and live, so software writes to them are dropped
  logic [7:0] system_mode_reg_view;
  always_comb begin
    system_mode_reg_view = system_mode_reg_r;
    system_mode_reg_view[LSCS_FRDY_BIT] = fast_ready;
    system_mode_reg_view[LSCS_SRDY_BIT] = slow_stable_f;
  end

  always_comb begin
    system_mode_reg_nxt = system_mode_reg_r;
    tbc_nxt = tbc_r;
    cfg_nxt = cfg_r;
    if (access_wr) begin
      case (paddr_i)
        LSCS_SYSTEM_MODE_REG_OFS: begin
          system_mode_reg_nxt = pwdata_i[7:0];
          system_mode_reg_nxt[LSCS_FRDY_BIT] = 1'b0;
          system_mode_reg_nxt[LSCS_SRDY_BIT] = 1'b0;
        end
        LSCS_TBC_OFS: begin
          tbc_nxt[LSCS_LP_BIT] = pwdata_i[LSCS_LP_BIT];
        end
        LSCS_CFG_OFS: begin
          cfg_nxt = {5'h00, pwdata_i[2:0]};
        end
        default: begin
          system_mode_reg_nxt = system_mode_reg_r;
        end
      endcase
    end
    // one cycle of pready per transfer, answered in the access phase
    pready_nxt = setup_ph;
    pslverr_nxt = setup_ph && !addr_hit(paddr_i);
    prdata_nxt = prdata_r;
    if (setup_ph && !pwrite_i) begin
      case (paddr_i)
        LSCS_SYSTEM_MODE_REG_OFS: prdata_nxt = {24'h000000, system_mode_reg_view};
        LSCS_TBC_OFS: prdata_nxt = {24'h000000, tbc_r};
        LSCS_CFG_OFS: prdata_nxt = {24'h000000, cfg_r};
        default: prdata_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      system_mode_reg_r <= LSCS_SYSTEM_MODE_REG_RST;
      tbc_r <= LSCS_TBC_RST;
      cfg_r <= LSCS_CFG_RST;
      prdata_r <= 32'h00000000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      system_mode_reg_r <= system_mode_reg_nxt;
      tbc_r <= tbc_nxt;
      cfg_r <= cfg_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // source routing

  logic fast_lvl_nxt;
  logic sub_lvl_nxt;
  logic tb_lvl_nxt;
  logic xtal_used;

  always_comb begin
    fast_lvl_nxt = cfg_r[LSCS_CFG_FAST_RC_BIT] ? fast_rc_f : fast_xtal_f;
    sub_lvl_nxt = cfg_r[LSCS_CFG_SUB_RC_BIT] ? slow_rc_f : slow_xtal_f;
    tb_lvl_nxt = cfg_r[LSCS_CFG_TB_RC_BIT] ? slow_rc_f : slow_xtal_f;
    xtal_used = !cfg_r[LSCS_CFG_SUB_RC_BIT] || !cfg_r[LSCS_CFG_TB_RC_BIT];
  end

  ////////////////////////////////////////////////////////////////////////////
  // system clock selection

  // divider code 010 is /64 (counter bit 5) down to 111 for /2 (bit 0)
  function automatic logic [2:0] sel_index(input logic hl, input logic [2:0] dv);
    if (hl) begin
      sel_index = LSCS_SRC_FAST;
    end else if (dv < 3'h2) begin
      sel_index = LSCS_SRC_SUB;
    end else begin
      sel_index = LSCS_SRC_DIV_BASE + (3'h7 - dv);
    end
  endfunction : sel_index

  logic fast_lvl_r;
  logic fast_prev_r;
  logic sub_lvl_r;
  logic tb_lvl_r;
  logic fast_en_r;
  logic fast_en_nxt;
  logic xtal_en_r;
  logic lp_r;
  logic [LSCS_DIV_W-1:0] div_clk;
  logic [LSCS_NSRC-1:0] mux_src;
  logic [2:0] target;
  logic [2:0] req;
  logic [2:0] mux_cur;
  logic mux_out;
  logic fast_tick;

  assign fast_ready = fast_en_r && fast_stable_f;
  assign fast_tick = fast_lvl_r && !fast_prev_r;
  assign target = sel_index(system_mode_reg_r[LSCS_HL_BIT], system_mode_reg_r[LSCS_DIV_LSB +: 3]);
  assign mux_src = {div_clk, fast_lvl_r, sub_lvl_r};

  // a fast target waits for a stable oscillator; meanwhile fast wake-up
  // runs the cpu from the substitute clock, otherwise the old source stays
  always_comb begin
    req = target;
    if ((target != LSCS_SRC_SUB) && !fast_ready) begin
      req = system_mode_reg_r[LSCS_FWAKE_BIT] ? LSCS_SRC_SUB : mux_cur;
    end
    // the fast oscillator stops only once the mux has really left it
    fast_en_nxt = (target != LSCS_SRC_SUB) || (mux_cur != LSCS_SRC_SUB);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fast_lvl_r <= 1'b0;
      fast_prev_r <= 1'b0;
      sub_lvl_r <= 1'b0;
      tb_lvl_r <= 1'b0;
      fast_en_r <= 1'b1;
      xtal_en_r <= 1'b1;
      lp_r <= 1'b0;
    end else begin
      fast_lvl_r <= fast_lvl_nxt && fast_en_r;
      fast_prev_r <= fast_lvl_r;
      sub_lvl_r <= sub_lvl_nxt;
      tb_lvl_r <= tb_lvl_nxt;
      fast_en_r <= fast_en_nxt;
      xtal_en_r <= xtal_used;
      lp_r <= tbc_r[LSCS_LP_BIT];
    end
  end

  lscs_fast_div #(
    .DIV_W(LSCS_DIV_W)
  ) u_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .fast_tick_i(fast_tick),
    .div_clk_o(div_clk)
  );

  // halt parks the cpu clock low; slow clocks below are never gated
  lscs_clk_mux #(
    .NSRC(LSCS_NSRC)
  ) u_mux (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .src_i(mux_src),
    .req_i(req),
    .run_i(!halt_i),
    .cur_o(mux_cur),
    .out_o(mux_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign prdata_o = prdata_r;
  assign pready_o = pready_r;
  assign pslverr_o = pslverr_r;
  assign fast_osc_en_o = fast_en_r;
  assign slow_crystal_en_o = xtal_en_r;
  assign slow_crystal_pins_osc_o = xtal_en_r;
  assign slow_crystal_low_power_select_o = lp_r;
  assign cpu_system_clock_o = mux_out;
  assign high_speed_clock_o = fast_lvl_r;
  assign substitute_clock_o = sub_lvl_r;
  assign time_base_clock_o = tb_lvl_r;
  assign watchdog_clock_o = sub_lvl_r;
  assign timer_slow_clock_o = sub_lvl_r;

endmodule : lscs_top
`default_nettype wire

// ---- test/lscs_top_properties.sv ----
// concurrent checks on the ports of the low-speed clock select top
// assumes one clock domain, reset synchronous and active high
`timescale 1ns/1ns
`default_nettype none
module lscs_top_properties (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic halt_i,
  input wire logic fast_osc_en_o,
  input wire logic slow_crystal_en_o,
  input wire logic slow_crystal_pins_osc_o,
  input wire logic slow_crystal_low_power_select_o,
  input wire logic cpu_system_clock_o,
  input wire logic high_speed_clock_o,
  input wire logic substitute_clock_o,
  input wire logic watchdog_clock_o,
  input wire logic timer_slow_clock_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic acc;
  assign acc = psel_i && penable_i && pready_o;
  ////////////////////////////////////////////////////////////////////////////
  property p_ready_setup;
    psel_i && !penable_i |=> pready_o;
  endproperty
  a_ready_setup: assert property (p_ready_setup) else $error("no ready after setup");
  property p_ready_pulse;
    pready_o |=> !pready_o;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");
  property p_err_map;
    acc |-> pslverr_o == !(paddr_i inside {8'h00, 8'h04, 8'h08});
  endproperty
  a_err_map: assert property (p_err_map) else $error("error flag does not match address map");
  property p_rd_clean;
    acc && !pwrite_i |-> prdata_o[31:8] == 24'h000000 && (!pslverr_o || prdata_o == 32'h00000000);
  endproperty
  a_rd_clean: assert property (p_rd_clean) else $error("read data not clean");
  property p_lp_follow;
    acc && pwrite_i && paddr_i == 8'h04 |=> ##1 slow_crystal_low_power_select_o == $past(pwdata_i[0], 2);
  endproperty
  a_lp_follow: assert property (p_lp_follow) else $error("low power select not following write");
  property p_lp_reset;
    $past(rst_i) |-> !slow_crystal_low_power_select_o;
  endproperty
  a_lp_reset: assert property (p_lp_reset) else $error("low power select set after reset");
  property p_pins;
    slow_crystal_pins_osc_o == slow_crystal_en_o;
  endproperty
  a_pins: assert property (p_pins) else $error("crystal pins and crystal enable differ");
  property p_slow_fan;
    watchdog_clock_o == substitute_clock_o && timer_slow_clock_o == substitute_clock_o;
  endproperty
  a_slow_fan: assert property (p_slow_fan) else $error("slow clock fan-out differs");
  property p_fast_off;
    !fast_osc_en_o && !$past(fast_osc_en_o) |-> !high_speed_clock_o;
  endproperty
  a_fast_off: assert property (p_fast_off) else $error("fast clock runs while stopped");
  property p_halt_park;
    halt_i && $past(halt_i) && $past(halt_i, 2) |-> !$rose(cpu_system_clock_o);
  endproperty
  a_halt_park: assert property (p_halt_park) else $error("cpu clock rose while halted");
  property p_no_runt;
    $rose(cpu_system_clock_o) |-> cpu_system_clock_o [*4];
  endproperty
  a_no_runt: assert property (p_no_runt) else $error("short high pulse on cpu clock");
endmodule : lscs_top_properties
bind lscs_top lscs_top_properties u_props (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .halt_i(halt_i), .fast_osc_en_o(fast_osc_en_o),
  .slow_crystal_en_o(slow_crystal_en_o), .slow_crystal_pins_osc_o(slow_crystal_pins_osc_o),
  .slow_crystal_low_power_select_o(slow_crystal_low_power_select_o), .cpu_system_clock_o(cpu_system_clock_o),
  .high_speed_clock_o(high_speed_clock_o), .substitute_clock_o(substitute_clock_o),
  .watchdog_clock_o(watchdog_clock_o), .timer_slow_clock_o(timer_slow_clock_o));
`default_nettype wire

// ---- test/tb_top.sv ----
// self-checking bench for the low-speed clock select top
// assumes oscillators modelled as slow square waves of the 100 MHz clock
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import lscs_pkg::*;
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} lscs_row_type;
  logic clk_i = 1'b0, rst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, halt_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h00000000, prdata_o, rd;
  logic pready_o, pslverr_o, er, fx = 1'b0, fr = 1'b0, sx = 1'b0, sr = 1'b0, fst = 1'b0, sst = 1'b0;
  logic fen, sen, pins, lp, cpu, hs, sub, tb, wd, tm;
  logic [4:0] mon;
  int errors = 0, n_checks = 0, cyc = 0, n;
  lscs_row_type rows [8] = '{'{1'b0, 8'h00, 32'h0, 32'h0f, 1'b0}, '{1'b0, 8'h04, 32'h0, 32'h00, 1'b0},
    '{1'b0, 8'h08, 32'h0, 32'h00, 1'b0}, '{1'b1, 8'h00, 32'hff, 32'h0, 1'b0},
    '{1'b0, 8'h00, 32'h0, 32'hff, 1'b0}, '{1'b1, 8'h0c, 32'h55, 32'h0, 1'b1},
    '{1'b0, 8'h0c, 32'h0, 32'h00, 1'b1}, '{1'b1, 8'h00, 32'h03, 32'h0, 1'b0}};
  assign mon = {tm, wd, sub, tb, cpu};
  lscs_top dut (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .ext_fast_crystal_osc_i(fx), .int_fast_rc_osc_i(fr), .ext_slow_crystal_osc_i(sx), .int_slow_rc_osc_i(sr),
    .fast_osc_stable_i(fst), .slow_osc_stable_i(sst), .halt_i(halt_i), .fast_osc_en_o(fen),
    .slow_crystal_en_o(sen), .slow_crystal_pins_osc_o(pins), .slow_crystal_low_power_select_o(lp),
    .cpu_system_clock_o(cpu), .high_speed_clock_o(hs), .substitute_clock_o(sub), .time_base_clock_o(tb),
    .watchdog_clock_o(wd), .timer_slow_clock_o(tm));
  ////////////////////////////////////////////////////////////////////////////
  always #5 clk_i = ~clk_i;
  // periods 16, 12, 128 and 80 cycles, each level held well past the pin filter
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc % 8 == 7) fx <= ~fx;
    if (cyc % 6 == 5) fr <= ~fr;
    if (cyc % 64 == 63) sx <= ~sx;
    if (cyc % 40 == 39) sr <= ~sr;
  end
  task automatic final_report;
    if (errors == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    // no wait limit here: the watchdog ends a transfer that never completes
    do begin
      @(posedge clk_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask : apb
  // waits for a low-to-high step of one monitored clock, counting edges
  task automatic rise(input int s, output int c);
    logic prv;
    prv = 1'b1;
    c = 0;
    while (c < 4000) begin
      @(posedge clk_i);
      c++;
      if (mon[s] === 1'b1 && prv === 1'b0) break;
      prv = mon[s];
    end
    if (c >= 4000) errors++;
  endtask : rise
  // first period after a switch may be irregular, so the third rise is timed
  task automatic meas(input int s, input int x);
    int c;
    rise(s, c);
    rise(s, c);
    rise(s, c);
    chk(32'(c), 32'(x));
  endtask : meas
  initial begin
    #500000;
    errors++;
    final_report();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(pready_o, 1'b0);
    chk(fen, 1'b1);
    chk(sen, 1'b1);
    chk(pins, 1'b1);
    chk(lp, 1'b0);
    apb(1'b0, LSCS_SYSTEM_MODE_REG_OFS, 32'h0);
    chk(rd, 32'h03);
    fst <= 1'b1;
    sst <= 1'b1;
    repeat (10) @(posedge clk_i);
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      chk(er, rows[i].e);
      if (!rows[i].w) chk(rd, rows[i].x);
    end
    apb(1'b1, LSCS_TBC_OFS, 32'h01);
    repeat (2) @(posedge clk_i);
    chk(lp, 1'b1);
    chk(sen, 1'b1);
    for (int k = 8; k >= 0; k--) begin
      apb(1'b1, LSCS_SYSTEM_MODE_REG_OFS, (k == 8) ? 32'h03 : 32'((k << 5) | 2));
      meas(0, (k == 8) ? 16 : (k < 2) ? 128 : 16 << (8 - k));
    end
    chk(fen, 1'b0);
    chk(hs, 1'b0);
    fst <= 1'b0;
    apb(1'b1, LSCS_SYSTEM_MODE_REG_OFS, 32'h03);
    repeat (20) @(posedge clk_i);
    chk(fen, 1'b1);
    apb(1'b0, LSCS_SYSTEM_MODE_REG_OFS, 32'h0);
    chk(rd, 32'h0b);
    meas(0, 128);
    fst <= 1'b1;
    meas(0, 16);
    // stable flag lost while running fast: without fast wake the source is kept
    fst <= 1'b0;
    meas(0, 16);
    // with fast wake the cpu falls back to the substitute clock until stable
    apb(1'b1, LSCS_SYSTEM_MODE_REG_OFS, 32'h13);
    meas(0, 128);
    fst <= 1'b1;
    meas(0, 16);
    // source options change only while the cpu clock is parked
    halt_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    chk(cpu, 1'b0);
    rise(2, n);
    apb(1'b1, LSCS_CFG_OFS, 32'h07);
    halt_i <= 1'b0;
    meas(0, 12);
    meas(1, 80);
    meas(3, 80);
    meas(4, 80);
    chk(sen, 1'b0);
    chk(pins, 1'b0);
    apb(1'b1, LSCS_SYSTEM_MODE_REG_OFS, 32'h02);
    meas(0, 80);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    chk(lp, 1'b0);
    chk(sen, 1'b1);
    chk(pins, 1'b1);
    apb(1'b0, LSCS_SYSTEM_MODE_REG_OFS, 32'h0);
    chk(rd, 32'h0f);
    apb(1'b0, LSCS_TBC_OFS, 32'h0);
    chk(rd, 32'h00);
    final_report();
  end
endmodule : tb_top
`default_nettype wire
